// [pkg/sled_defines.vh]
// constants for the status led / gpio pin block
// assumes inclusion by bare name from logic files
`ifndef SLED_DEFINES_VH
`define SLED_DEFINES_VH
`define SLED_NUM_LINES 3
`define SLED_CLK_MHZ 100
`define SLED_BLINK_MS 80
`define SLED_BLINK_CYCLES (`SLED_BLINK_MS * 1000 * `SLED_CLK_MHZ)
`define SLED_TYPE_INPUT 2'h0
`define SLED_TYPE_PUSHPULL 2'h1
`define SLED_TYPE_OPENDRAIN 2'h2
`define SLED_LINE_SPEED 0
`define SLED_LINE_LINK 1
`define SLED_LINE_DUPLEX 2
`define SLED_ST_DARK 2'h0
`define SLED_ST_ON 2'h1
`define SLED_ST_OFF 2'h2
`define SLED_ST_HOLD 2'h3
`endif

// [logic/sled_blink.v]
// link and activity blinker: off pulse then a guaranteed on time
// assumes link and activity flags synchronous to core_clk
`timescale 1ns/1ns
`include "sled_defines.vh"
module sled_blink #(
	parameter BLINK_CYCLES = `SLED_BLINK_CYCLES
) (
	input wire core_clk,
	input wire rst,
	input wire link_up,
	input wire activity,
	output reg led_n
);
	reg [1:0] state;
	reg [31:0] count;
	reg [1:0] next_state;
	reg [31:0] next_count;
	reg next_led_n;
	always @* begin
		next_state = state;
		next_count = count;
		next_led_n = 1'b1;
		case (state)
			`SLED_ST_DARK: begin
				if (link_up) begin
					next_state = `SLED_ST_ON;
					next_led_n = 1'b0;
				end
			end
			`SLED_ST_ON: begin
				next_led_n = 1'b0; // R6
				if (!link_up) begin
					next_state = `SLED_ST_DARK;
					next_led_n = 1'b1;
				end else if (activity) begin
					next_state = `SLED_ST_OFF; // R7
					next_count = 32'h0000_0000;
					next_led_n = 1'b1;
				end
			end
			`SLED_ST_OFF: begin
				next_count = count + 32'h0000_0001;
				if (!link_up) begin
					next_state = `SLED_ST_DARK;
				end else if (count >= BLINK_CYCLES - 1) begin
					next_state = `SLED_ST_HOLD; // R8
					next_count = 32'h0000_0000;
					next_led_n = 1'b0;
				end
			end
			`SLED_ST_HOLD: begin
				next_led_n = 1'b0;
				next_count = count + 32'h0000_0001;
				if (!link_up) begin
					next_state = `SLED_ST_DARK;
					next_led_n = 1'b1;
				end else if (count >= BLINK_CYCLES - 1) begin
					next_state = `SLED_ST_ON; // R8
				end
			end
			default: begin
				next_state = `SLED_ST_DARK;
			end
		endcase
	end
	always @(posedge core_clk) begin
		if (rst) begin
			state <= `SLED_ST_DARK;
			count <= 32'h0000_0000;
			led_n <= 1'b1;
		end else begin
			state <= next_state;
			count <= next_count;
			led_n <= next_led_n;
		end
	end
endmodule

// [logic/sled_gpio.v]
// three gpio lines multiplexed with active-low status leds, plus crossover strap
// assumes phy status inputs and pin inputs synchronous to core_clk
// Operation
// (R1) Auto crossover is enabled when the strap reads high or floating and disabled when low.
// (R2) Each line is configurable as push-pull output, open-drain output or input.
// (R3) A line in led function is driven open-drain whatever its output type.
// (R4) The speed led is low while the link runs at 100Mb.
// (R5) The speed led is high in negotiation, with no cable and at 10Mbs.
// (R6) The link and activity led is low while a valid link exists.
// (R7) Activity while linked turns the link led off for 80mS.
// (R8) After each off pulse the link led stays low at least 80mS before another.
// (R9) The duplex led is low in full duplex and high otherwise.
// (R10) A per-line led select bit defaults to gpio function after reset.
`timescale 1ns/1ns
`include "sled_defines.vh"
module sled_gpio #(
	parameter NUM_LINES = `SLED_NUM_LINES,
	parameter BLINK_CYCLES = `SLED_BLINK_CYCLES
) (
	input wire core_clk,
	input wire rst,
	input wire crossover_auto_strap,
	input wire [NUM_LINES-1:0] cfg_led_sel,
	input wire [2*NUM_LINES-1:0] cfg_out_type,
	input wire [NUM_LINES-1:0] cfg_out_data,
	input wire phy_link_up,
	input wire phy_speed_100,
	input wire phy_full_duplex,
	input wire phy_autoneg_busy,
	input wire phy_activity,
	input wire [NUM_LINES-1:0] gpio_in,
	output wire [NUM_LINES-1:0] gpio_out,
	output wire [NUM_LINES-1:0] gpio_oe,
	output wire [NUM_LINES-1:0] gpio_rd_data,
	output reg crossover_auto_en
);
	wire link_led_n;
	reg [NUM_LINES-1:0] led_sel;
	reg [2*NUM_LINES-1:0] out_type;
	reg speed_led_n;
	reg duplex_led_n;
	// strap is sampled every clock after reset, so a late pull settles in
	always @(posedge core_clk) begin
		if (rst) begin
			crossover_auto_en <= 1'b1;
		end else begin
			crossover_auto_en <= crossover_auto_strap; // R1
		end
	end
	// configuration is latched so reset forces gpio input
	always @(posedge core_clk) begin
		if (rst) begin
			led_sel <= {NUM_LINES{1'b0}}; // R10
			out_type <= {2*NUM_LINES{1'b0}};
		end else begin
			led_sel <= cfg_led_sel; // R10
			out_type <= cfg_out_type; // R2
		end
	end
	always @(posedge core_clk) begin
		if (rst) begin
			speed_led_n <= 1'b1;
			duplex_led_n <= 1'b1;
		end else begin
			speed_led_n <= !(phy_link_up && phy_speed_100 && !phy_autoneg_busy); // R4 R5
			duplex_led_n <= !(phy_link_up && phy_full_duplex); // R9
		end
	end
	sled_blink #(
		.BLINK_CYCLES(BLINK_CYCLES)
	) u_blink (
		.core_clk(core_clk),
		.rst(rst),
		.link_up(phy_link_up),
		.activity(phy_activity),
		.led_n(link_led_n)
	);
	function [0:0] led_level;
		input integer idx;
		input s, l, d;
		begin
			if (idx == `SLED_LINE_SPEED) led_level = s;
			else if (idx == `SLED_LINE_LINK) led_level = l;
			else led_level = d;
		end
	endfunction
	genvar i;
	generate
		for (i = 0; i < NUM_LINES; i = i + 1) begin : g_line
			wire [1:0] ty = out_type[2*i+1:2*i];
			// one flop set per line keeps each output bit to a single driver
			reg out_q;
			reg oe_q;
			reg rd_q;
			assign gpio_out[i] = out_q;
			assign gpio_oe[i] = oe_q;
			assign gpio_rd_data[i] = rd_q;
			always @(posedge core_clk) begin
				if (rst) begin
					out_q <= 1'b0;
					oe_q <= 1'b0;
					rd_q <= 1'b0;
				end else begin
					rd_q <= gpio_in[i];
					if (led_sel[i]) begin
						// open drain: drive only the low level
						out_q <= 1'b0; // R3
						oe_q <= !led_level(i, speed_led_n, link_led_n, duplex_led_n); // R3
					end else if (ty == `SLED_TYPE_PUSHPULL) begin
						out_q <= cfg_out_data[i]; // R2
						oe_q <= 1'b1;
					end else if (ty == `SLED_TYPE_OPENDRAIN) begin
						out_q <= 1'b0; // R2
						oe_q <= !cfg_out_data[i];
					end else begin
						out_q <= 1'b0; // R2
						oe_q <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule

// [testbench/sled_gpio_sva.sv]
// checker for the gpio and led pin block, port timing only
// assumes bind onto sled_gpio with the same blink count
`timescale 1ns/1ns
module sled_gpio_sva #(
	parameter BLINK_CYCLES = 20
) (
	input wire core_clk,
	input wire rst,
	input wire crossover_auto_strap,
	input wire [2:0] cfg_led_sel,
	input wire phy_link_up,
	input wire phy_speed_100,
	input wire phy_full_duplex,
	input wire phy_autoneg_busy,
	input wire [2:0] gpio_in,
	input wire [2:0] gpio_out,
	input wire [2:0] gpio_oe,
	input wire [2:0] gpio_rd_data,
	input wire crossover_auto_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// history guards keep $past away from reset and from select changes
	reg [2:0] rh = 3'h7;
	reg [8:0] sh = 9'h0;
	reg [15:0] lo = 16'h0;
	wire ok = rh == 3'h0;
	wire [2:0] sl = sh[2:0] & sh[5:3] & sh[8:6];
	always @(posedge core_clk) begin
		rh <= {rh[1:0], rst};
		sh <= {sh[5:0], cfg_led_sel};
		lo <= gpio_oe[1] ? 16'h0 : lo + 16'h1;
	end
	chk_strap_follow: assert property (ok |-> crossover_auto_en == $past(crossover_auto_strap))
		else $error("strap not followed");
	chk_rd_delay: assert property (ok |-> gpio_rd_data == $past(gpio_in))
		else $error("pin read wrong");
	chk_led_od: assert property (ok |-> (gpio_out & sl) == 3'h0) else $error("led driven high");
	chk_speed_led: assert property (ok && sl[0] |-> gpio_oe[0] ==
		$past(phy_link_up && phy_speed_100 && !phy_autoneg_busy, 2)) else $error("speed led");
	chk_duplex_led: assert property (ok && sl[2] |-> gpio_oe[2] ==
		$past(phy_link_up && phy_full_duplex, 2)) else $error("duplex led");
	chk_link_on: assert property (ok && sl[1] && $past(phy_link_up, 2) &&
		!$past(phy_link_up, 3) |-> gpio_oe[1]) else $error("link led not lit");
	chk_link_drop: assert property (ok && sl[1] && !$past(phy_link_up, 2) |-> !gpio_oe[1])
		else $error("link led lit without link");
	chk_blink_len: assert property (ok && sl[1] && $rose(gpio_oe[1]) &&
		$past(phy_link_up, 3) |-> lo == BLINK_CYCLES) else $error("off pulse length");
	cover property (ok && $rose(gpio_oe[1]) && phy_link_up);
	cover property (ok && sl[0] && gpio_oe[0]);
	cover property (ok && !crossover_auto_en);
endmodule

// [testbench/sled_board.sv]
// board side of the three lines: pull-ups, leds and outside drivers
// assumes oe high while the block drives a line
`timescale 1ns/1ns
module sled_board (
	input wire [2:0] gpio_out,
	input wire [2:0] gpio_oe,
	input wire [2:0] ext_drv,
	output wire [2:0] gpio_in
);
	// a released line shows the board level, idle at the pull-up
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_drv);
endmodule

// [testbench/sled_gpio_tb.sv]
// directed bench for the gpio and led pin block
// assumes 100 MHz core clock and a shortened blink count
`timescale 1ns/1ns
module sled_gpio_tb;
	localparam B = 20;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg crossover_auto_strap = 1'b1;
	reg phy_link_up = 1'b0;
	reg phy_speed_100 = 1'b0;
	reg phy_full_duplex = 1'b0;
	reg phy_autoneg_busy = 1'b0;
	reg phy_activity = 1'b0;
	reg [2:0] cfg_led_sel = 3'h0;
	reg [2:0] cfg_out_data = 3'h0;
	reg [2:0] ext_drv = 3'h7;
	reg [5:0] cfg_out_type = 6'h00;
	wire [2:0] gpio_out, gpio_oe, gpio_rd_data, gpio_in;
	wire crossover_auto_en;
	integer err_total = 0, checked = 0, n;
	sled_gpio #(.BLINK_CYCLES(B)) i_sled_gpio (.*);
	sled_board i_sled_board (.*);
	initial forever #5 core_clk = ~core_clk;
	task w(input integer c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
		checked = checked + 1;
		if (exp !== got) begin
			err_total = err_total + 1;
			$display("Error %0s expected %h seen %h", what, exp, got);
		end
	endtask
	task run(input v);
		n = 0;
		while (gpio_oe[1] === v && n < 99) begin
			w(1);
			n = n + 1;
		end
	endtask
	task t_gpio;
		chk("oe", 3'h0, gpio_oe);
		cfg_out_type <= 6'h39;
		cfg_out_data <= 3'h2;
		w(3);
		chk("pins", 3'h6, gpio_rd_data);
		chk("oe", 3'h1, gpio_oe);
		cfg_out_data <= 3'h1;
		ext_drv <= 3'h3;
		w(2);
		chk("pins", 3'h1, gpio_rd_data);
		chk("oe", 3'h3, gpio_oe);
		$display("gpio done");
	endtask
	task t_strap;
		crossover_auto_strap <= 1'b0;
		w(1);
		chk("xover", 1'b0, crossover_auto_en);
		crossover_auto_strap <= 1'b1;
		w(1);
		chk("xover", 1'b1, crossover_auto_en);
		$display("strap done");
	endtask
	task t_led;
		cfg_led_sel <= 3'h7;
		phy_link_up <= 1'b1;
		phy_speed_100 <= 1'b1;
		phy_full_duplex <= 1'b1;
		w(3);
		chk("oe", 3'h7, gpio_oe);
		chk("out", 3'h0, gpio_out);
		phy_speed_100 <= 1'b0;
		phy_full_duplex <= 1'b0;
		w(3);
		chk("oe", 3'h2, gpio_oe);
		phy_speed_100 <= 1'b1;
		phy_autoneg_busy <= 1'b1;
		w(3);
		chk("oe", 3'h2, gpio_oe);
		$display("led done");
	endtask
	task t_blink;
		phy_activity <= 1'b1;
		w(1);
		phy_activity <= 1'b0;
		run(1);
		run(0);
		chk("off", B, n);
		phy_activity <= 1'b1;
		run(1);
		chk("on", 1'b1, n >= B);
		run(0);
		chk("off", B, n);
		phy_link_up <= 1'b0;
		phy_activity <= 1'b0;
		w(3);
		chk("dark", 3'h0, gpio_oe);
		phy_link_up <= 1'b1;
		w(3);
		chk("relink", 3'h2, gpio_oe);
		$display("blink done");
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		w(4);
		rst <= 1'b0;
		w(1);
		t_gpio;
		t_strap;
		t_led;
		t_blink;
		print_verdict;
	end
	initial begin
		#20000;
		err_total = err_total + 1;
		print_verdict;
	end
endmodule
bind sled_gpio sled_gpio_sva #(.BLINK_CYCLES(BLINK_CYCLES)) i_sled_gpio_sva (.*);
